/* src/cpu_bus_cycle_sequencer.sv */
// Bus cycle sequencer: runs refresh, read, write, acknowledge and halt cycles.
// Assumes requests and ready are synchronous to clk; one request at a time.
`include "bus_seq_consts.svh"
module cpu_bus_cycle_sequencer #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration: high for a 16-bit data bus
  input wire logic bus16,
  // Cycle request from the core
  input wire logic req_valid,
  input wire bus_seq_pkg::kind_t req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_word,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic [7:0] vector,
  output logic vector_valid,
  // Wake events while halted
  input wire logic wake_irq,
  input wire logic wake_temp,
  output logic halted,
  // Bus pins
  input wire logic bus_ready,
  input wire logic [DATA_W-1:0] ad_in,
  output logic [DATA_W-1:0] ad_out,
  output logic [DATA_W-1:0] ad_oe_n,
  output logic [7:0] upper_address_byte,
  output logic [3:0] upper_address_nibble,
  output logic ale,
  output logic [2:0] cycle_status,
  output logic rd_n,
  output logic wr_n,
  output logic interrupt_ack_strobe_n,
  output logic upper_byte_enable_n,
  output logic refresh_indicator_n,
  output logic transceiver_enable_n,
  output logic transceiver_direction,
  output logic lock_n,
  output logic chip_select_en
);
  // Cycle timing beyond T3 is decided by the helper below.
  tstate_if tif ();
  tstate_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  bus_seq_pkg::state_t state_r, state_nxt;
  bus_seq_pkg::kind_t kind_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic word_r;
  logic second_r;
  logic last_write_r;
  logic hold_data_r;
  logic temp_exit_r;

  assign tif.state = state_r;
  assign tif.ready = bus_ready;

  wire is_write = (kind_r == bus_seq_pkg::KIND_MEMWR) || (kind_r == bus_seq_pkg::KIND_IOWR);
  wire is_io = (kind_r == bus_seq_pkg::KIND_IORD) || (kind_r == bus_seq_pkg::KIND_IOWR);
  wire is_interrupt_ack_strobe = (kind_r == bus_seq_pkg::KIND_INTERRUPT_ACK_STROBE);
  wire is_halt = (kind_r == bus_seq_pkg::KIND_HALT);
  wire is_refresh_indicator = (kind_r == bus_seq_pkg::KIND_REFRESH);
  wire is_read = !is_write && !is_halt;
  wire t3_end = tif.t3_done;
  wire idle_like = (state_r == bus_seq_pkg::ST_IDLE) || (state_r == bus_seq_pkg::ST_HALTED);
  wire take = idle_like && req_valid && !(state_r == bus_seq_pkg::ST_HALTED && !wake_temp
    && !wake_irq);
  // After a temporary exit, an idle sequencer returns to halt with no request and no halt cycle.
  wire rehalt = (state_r == bus_seq_pkg::ST_IDLE) && temp_exit_r;

  // Status code for the cycle in progress, from the held kind.
  logic [2:0] status_sel;
  always_comb begin
    case (kind_r)
      bus_seq_pkg::KIND_MEMRD: status_sel = `STAT_MEMRD;
      bus_seq_pkg::KIND_REFRESH: status_sel = `STAT_MEMRD;
      bus_seq_pkg::KIND_IORD: status_sel = `STAT_IORD;
      bus_seq_pkg::KIND_PREF: status_sel = `STAT_PREF;
      bus_seq_pkg::KIND_MEMWR: status_sel = `STAT_MEMWR;
      bus_seq_pkg::KIND_IOWR: status_sel = `STAT_IOWR;
      bus_seq_pkg::KIND_INTERRUPT_ACK_STROBE: status_sel = `STAT_INTERRUPT_ACK_STROBE;
      bus_seq_pkg::KIND_HALT: status_sel = `STAT_HALT;
      default: status_sel = `STAT_PASSIVE;
    endcase
  end

  // Address with refresh forcing A0 high.
  wire [ADDR_W-1:0] addr_eff = is_refresh_indicator ? (addr_r | {{(ADDR_W-1){1'b0}}, 1'b1}) : addr_r;
  // I/O cycles drive the top nibble to zero.
  wire [3:0] nib_addr = is_io ? `NIBBLE_ZERO : addr_eff[ADDR_W-1:ADDR_W-4];
  // Upper enable: high on refresh, else low for word or odd byte on a 16-bit bus.
  wire ube_lvl_n = is_refresh_indicator ? 1'b1 : !(bus16 && (word_r || addr_r[0]));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bus_seq_pkg::ST_IDLE: if (take || rehalt) state_nxt = rehalt && !take ?
        bus_seq_pkg::ST_HALTED : bus_seq_pkg::ST_T1;
      bus_seq_pkg::ST_T1: state_nxt = bus_seq_pkg::ST_T2;
      bus_seq_pkg::ST_T2: state_nxt = bus_seq_pkg::ST_T3;
      bus_seq_pkg::ST_T3: state_nxt = is_halt ? bus_seq_pkg::ST_HALTED :
        (t3_end ? bus_seq_pkg::ST_T4 : bus_seq_pkg::ST_TW);
      bus_seq_pkg::ST_TW: if (t3_end) state_nxt = bus_seq_pkg::ST_T4;
      bus_seq_pkg::ST_T4: state_nxt = interrupt_ack_strobe_again ? bus_seq_pkg::ST_T1 : bus_seq_pkg::ST_IDLE;
      bus_seq_pkg::ST_HALTED: if (take) state_nxt = bus_seq_pkg::ST_T1;
      default: state_nxt = bus_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= bus_seq_pkg::ST_IDLE;
      kind_r <= bus_seq_pkg::KIND_PREF;
      addr_r <= '0;
      wdata_r <= '0;
      word_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        kind_r <= req_kind;
        addr_r <= req_addr;
        wdata_r <= req_wdata;
        word_r <= req_word;
      end
    end
  end

  // Second acknowledge cycle follows the first with no request in between.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) second_r <= 1'b0;
    else if (state_r == bus_seq_pkg::ST_T4 && is_interrupt_ack_strobe) second_r <= !second_r;
  end
  wire interrupt_ack_strobe_again = is_interrupt_ack_strobe && !second_r;

  // Temporary exit: a request while halted, then a return without a halt cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) temp_exit_r <= 1'b0;
    else if (state_r == bus_seq_pkg::ST_HALTED && take) temp_exit_r <= !wake_irq;
    else if (state_r == bus_seq_pkg::ST_IDLE) temp_exit_r <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) last_write_r <= 1'b0;
    else if (state_r == bus_seq_pkg::ST_T4) last_write_r <= is_write;
  end

  // Write data held into the clock after the strobe rises.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_data_r <= 1'b0;
    else hold_data_r <= (state_nxt == bus_seq_pkg::ST_T4) && is_write;
  end

  // Values of the cycle being launched, taken from the request or the held copy.
  wire bus_seq_pkg::kind_t kind_nxt = take ? req_kind : kind_r;
  wire [ADDR_W-1:0] addr_raw = take ? req_addr : addr_r;
  wire is_refresh_indicator_nxt = (kind_nxt == bus_seq_pkg::KIND_REFRESH);
  wire is_interrupt_ack_strobe_nxt = (kind_nxt == bus_seq_pkg::KIND_INTERRUPT_ACK_STROBE);
  wire is_halt_nxt = (kind_nxt == bus_seq_pkg::KIND_HALT);
  wire is_io_nxt = (kind_nxt == bus_seq_pkg::KIND_IORD) ||
    (kind_nxt == bus_seq_pkg::KIND_IOWR);
  wire [ADDR_W-1:0] addr_nxt = is_refresh_indicator_nxt ? (addr_raw | {{(ADDR_W-1){1'b0}}, 1'b1}) :
    addr_raw;
  wire [3:0] nib_nxt = is_io_nxt ? `NIBBLE_ZERO : addr_nxt[ADDR_W-1:ADDR_W-4];
  wire ube_nxt = is_refresh_indicator_nxt ? 1'b1 : !(bus16 && ((take ? req_word : word_r) || addr_raw[0]));

  // Pin registers.
  logic active;
  assign active = !idle_like;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ale <= 1'b0;
      cycle_status <= `STAT_PASSIVE;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      interrupt_ack_strobe_n <= 1'b1;
      upper_byte_enable_n <= 1'b1;
      refresh_indicator_n <= 1'b1;
      transceiver_enable_n <= 1'b1;
      transceiver_direction <= 1'b1;
      lock_n <= 1'b1;
      chip_select_en <= 1'b0;
      ad_out <= '0;
      ad_oe_n <= '1;
      upper_address_byte <= 8'h00;
      upper_address_nibble <= `NIBBLE_ZERO;
    end else begin
      // Latch strobe and status open every cycle.
      ale <= (state_nxt == bus_seq_pkg::ST_T1);
      cycle_status <= (state_nxt == bus_seq_pkg::ST_T1) ? status_sel_next() :
        (state_nxt == bus_seq_pkg::ST_HALTED ? `STAT_PASSIVE : cycle_status);
      rd_n <= !(is_read && !is_interrupt_ack_strobe && !idle_like && (state_nxt == bus_seq_pkg::ST_T2 ||
        state_nxt == bus_seq_pkg::ST_T3 || state_nxt == bus_seq_pkg::ST_TW));
      interrupt_ack_strobe_n <= !(is_interrupt_ack_strobe && (state_nxt == bus_seq_pkg::ST_T2 ||
        state_nxt == bus_seq_pkg::ST_T3 || state_nxt == bus_seq_pkg::ST_TW));
      // Strobe covers T2 through wait states; rises entering T4.
      wr_n <= !(is_write && (state_nxt == bus_seq_pkg::ST_T2 ||
        state_nxt == bus_seq_pkg::ST_T3 || state_nxt == bus_seq_pkg::ST_TW));
      // Refresh indicator tracks the upper enable timing.
      if (state_nxt == bus_seq_pkg::ST_T1) begin
        upper_byte_enable_n <= ube_nxt;
        refresh_indicator_n <= !(is_refresh_indicator_nxt && !bus16);
      end else if (state_nxt == bus_seq_pkg::ST_HALTED) begin
        refresh_indicator_n <= 1'b1;
      end
      transceiver_enable_n <= !(active && !is_halt && state_nxt != bus_seq_pkg::ST_T1 &&
        state_nxt != bus_seq_pkg::ST_IDLE);
      // Direction low only for reads, fetches and acknowledge.
      transceiver_direction <= (state_nxt == bus_seq_pkg::ST_HALTED) ? 1'b1 :
        !(active && is_read && !is_halt);
      lock_n <= !(is_interrupt_ack_strobe && (interrupt_ack_strobe_again || state_r != bus_seq_pkg::ST_T4)
        && active);
      chip_select_en <= active && !is_halt && !is_interrupt_ack_strobe;
      // Muxed bus drive.
      if (state_nxt == bus_seq_pkg::ST_T1 && !(is_interrupt_ack_strobe_nxt || is_halt_nxt)) begin
        ad_out <= addr_nxt[DATA_W-1:0];
        ad_oe_n <= '0;
      end else if (state_nxt == bus_seq_pkg::ST_T1 && is_halt_nxt && last_write_r) begin
        ad_oe_n <= '0;
      end else if (is_write && state_nxt != bus_seq_pkg::ST_IDLE) begin
        ad_out <= wdata_r;
        ad_oe_n <= '0;
      end else if (hold_data_r) begin
        ad_oe_n <= '0;
      end else begin
        ad_oe_n <= '1;
      end
      if (state_nxt == bus_seq_pkg::ST_T1 && !is_halt_nxt) begin
        upper_address_byte <= is_interrupt_ack_strobe_nxt ? upper_address_byte : addr_nxt[15:8];
        upper_address_nibble <= nib_nxt;
      end
    end
  end

  function automatic logic [2:0] status_sel_next();
    case (kind_nxt)
      bus_seq_pkg::KIND_MEMRD: return `STAT_MEMRD;
      bus_seq_pkg::KIND_REFRESH: return `STAT_MEMRD;
      bus_seq_pkg::KIND_IORD: return `STAT_IORD;
      bus_seq_pkg::KIND_PREF: return `STAT_PREF;
      bus_seq_pkg::KIND_MEMWR: return `STAT_MEMWR;
      bus_seq_pkg::KIND_IOWR: return `STAT_IOWR;
      bus_seq_pkg::KIND_INTERRUPT_ACK_STROBE: return `STAT_INTERRUPT_ACK_STROBE;
      default: return `STAT_HALT;
    endcase
  endfunction

  // Core handshake and read data capture.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      vector <= 8'h00;
      vector_valid <= 1'b0;
      halted <= 1'b0;
    end else begin
      req_ready <= (state_nxt == bus_seq_pkg::ST_IDLE && !rehalt) ||
        state_nxt == bus_seq_pkg::ST_HALTED;
      done <= (state_r == bus_seq_pkg::ST_T4) && !interrupt_ack_strobe_again;
      // Refresh data is ignored.
      if (t3_end && is_read && !is_refresh_indicator && !is_interrupt_ack_strobe) rdata <= ad_in;
      vector_valid <= t3_end && is_interrupt_ack_strobe && second_r;
      if (t3_end && is_interrupt_ack_strobe && second_r) vector <= ad_in[7:0];
      halted <= (state_nxt == bus_seq_pkg::ST_HALTED);
    end
  end
endmodule

/* src/bus_seq_consts.svh */
// Constants for the bus cycle sequencer: status codes, pin levels and timing.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BUS_SEQ_CONSTS_SVH
`define BUS_SEQ_CONSTS_SVH
`define STAT_INTERRUPT_ACK_STROBE 3'h0
`define STAT_IORD 3'h1
`define STAT_IOWR 3'h2
`define STAT_HALT 3'h3
`define STAT_PREF 3'h4
`define STAT_MEMRD 3'h5
`define STAT_MEMWR 3'h6
`define STAT_PASSIVE 3'h7
`define NIBBLE_ZERO 4'h0
`define NIBBLE_HALT_DMA 4'h8
`define DATA_SETUP_CLKS 2
`define DATA_HOLD_CLKS 1
`endif

/* src/bus_seq_pkg.sv */
// Types shared by the bus cycle sequencer and its timing helper.
// Assumes nothing beyond a SystemVerilog compiler.
package bus_seq_pkg;
  typedef enum logic [2:0] {
    KIND_MEMRD = 3'h0,
    KIND_IORD = 3'h1,
    KIND_PREF = 3'h2,
    KIND_MEMWR = 3'h3,
    KIND_IOWR = 3'h4,
    KIND_REFRESH = 3'h5,
    KIND_INTERRUPT_ACK_STROBE = 3'h6,
    KIND_HALT = 3'h7
  } kind_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1 = 3'h1,
    ST_T2 = 3'h2,
    ST_T3 = 3'h3,
    ST_TW = 3'h4,
    ST_T4 = 3'h5,
    ST_HALTED = 3'h6
  } state_t;
endpackage

/* src/tstate_if.sv */
// Carries the T-state of the current cycle from the sequencer to its helper.
// Assumes both ends share one clock.
interface tstate_if;
  logic [2:0] state;
  logic ready;
  logic t3_done;
  modport seq(output state, output ready, input t3_done);
  modport tim(input state, input ready, output t3_done);
endinterface

/* src/tstate_timer.sv */
// Decides when T3 or a wait state ends, from the sampled bus ready.
// Assumes the sequencer drives state and ready on the same clock.
module tstate_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link to the sequencer
  tstate_if.tim tif
);
  // Each wait state held here lengthens the cycle and the strobe.
  wire in_data_phase = (tif.state == bus_seq_pkg::ST_T3) || (tif.state == bus_seq_pkg::ST_TW);
  // Blocks a second end in the clock right after one, while the state moves on.
  logic done_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) done_r <= 1'b0;
    else done_r <= tif.t3_done;
  end
  assign tif.t3_done = in_data_phase && tif.ready && !done_r;
endmodule

/* tb/bus_partner.sv */
// Far-side model: ready timing, noise data and an interrupt vector behind strobes.
// Assumes active-low strobes and a 16-bit data path to the sequencer.
module bus_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings from the bench
  input wire logic [3:0] waits,
  input wire logic [7:0] vec,
  // Bus pins
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic interrupt_ack_strobe_n,
  output logic bus_ready,
  output logic [15:0] ad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_r;
  logic [15:0] noise_r;
  wire logic strobe = !rd_n || !wr_n || !interrupt_ack_strobe_n;
  // Nothing here decodes the address, so every strobed cycle is answered.
  assign bus_ready = strobe && (cnt_r > waits);
  // Undriven lines churn every cycle, so a floating half never reads as data.
  assign ad_in = interrupt_ack_strobe_n ? noise_r : {noise_r[15:8], vec};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      noise_r <= 16'h5a3c;
    end else begin
      cnt_r <= strobe ? cnt_r + 4'h1 : 4'h0;
      noise_r <= {noise_r[14:0], noise_r[15] ^ noise_r[12]};
    end
  end
endmodule

/* tb/seq_checker.sv */
// Assertions on the bus pins of the cycle sequencer.
// Assumes it is bound to the top module and sees only its ports.
module seq_checker #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins watched
  input wire logic bus16,
  input wire logic [DATA_W-1:0] ad_oe_n,
  input wire logic ale,
  input wire logic [2:0] cycle_status,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic interrupt_ack_strobe_n,
  input wire logic refresh_indicator_n,
  input wire logic transceiver_enable_n,
  input wire logic transceiver_direction,
  input wire logic lock_n,
  input wire logic chip_select_en,
  input wire logic halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ale_status; $rose(ale) |-> cycle_status != 3'h7; endproperty
  a_ale_status: assert property (p_ale_status) else $error("no status at ale");
  property p_refresh_indicator; $fell(refresh_indicator_n) |-> !bus16 && ale; endproperty
  a_refresh_indicator: assert property (p_refresh_indicator) else $error("refresh flag misplaced");
  property p_wr_setup; $fell(wr_n) |-> (!wr_n && ad_oe_n[7:0] == 8'h00) [*2]; endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("write data setup short");
  property p_wr_hold; $rose(wr_n) |-> ##1 ad_oe_n[7:0] == 8'h00; endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data hold short");
  property p_ack_lock; !interrupt_ack_strobe_n |-> !lock_n; endproperty
  a_ack_lock: assert property (p_ack_lock) else $error("ack without lock");
  property p_ack_rd; !interrupt_ack_strobe_n |-> rd_n && !transceiver_direction; endproperty
  a_ack_rd: assert property (p_ack_rd) else $error("ack strobe misuse");
  property p_ack_float; $rose(ale) && cycle_status == 3'h0 |-> ad_oe_n == '1; endproperty
  a_ack_float: assert property (p_ack_float) else $error("ack drives address");
  property p_wr_dir; !wr_n |-> transceiver_direction; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("write direction low");
  property p_halt_cs; cycle_status == 3'h3 |-> !chip_select_en; endproperty
  a_halt_cs: assert property (p_halt_cs) else $error("select in halt cycle");
  property p_halt_pins;
    halted |-> rd_n && wr_n && transceiver_enable_n && transceiver_direction
      && cycle_status == 3'h7;
  endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("halt pin levels");
  c_write: cover property ($fell(wr_n));
  c_ack: cover property ($fell(lock_n));
  c_halt: cover property ($rose(halted));
endmodule

bind cpu_bus_cycle_sequencer seq_checker #(.DATA_W(DATA_W)) i_chk (.clk, .rst, .bus16,
  .ad_oe_n, .ale, .cycle_status, .rd_n, .wr_n, .interrupt_ack_strobe_n, .refresh_indicator_n,
  .transceiver_enable_n, .transceiver_direction, .lock_n, .chip_select_en, .halted);

/* tb/tb_top.sv */
// Self-checking bench for the bus cycle sequencer and its far-side model.
// Assumes the design files, partner model and checker compile first.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, bus16, req_valid, req_word, wake_irq, wake_temp, bus_ready, req_ready;
  logic done, vector_valid, halted, ale, rd_n, wr_n, interrupt_ack_strobe_n, lock_n;
  logic upper_byte_enable_n, refresh_indicator_n, transceiver_enable_n;
  logic transceiver_direction, chip_select_en, ube_ale, refresh_indicator_lo, lock_lo, hold_ok;
  bus_seq_pkg::kind_t req_kind;
  logic [19:0] req_addr;
  logic [15:0] req_wdata, rdata, ad_in, ad_out, ad_oe_n, ad_ale, wr_dat;
  logic [7:0] vector, upper_address_byte, vec, vec_got;
  logic [3:0] upper_address_nibble, waits, nib_ale;
  logic [2:0] cycle_status, st_ale;
  int failures, total_checks, ale_cnt, ack_cnt, wr_lo;

  cpu_bus_cycle_sequencer i_dut (.clk, .rst, .bus16, .req_valid, .req_kind, .req_addr,
    .req_wdata, .req_word, .req_ready, .done, .rdata, .vector, .vector_valid, .wake_irq,
    .wake_temp, .halted, .bus_ready, .ad_in, .ad_out, .ad_oe_n, .upper_address_byte,
    .upper_address_nibble, .ale, .cycle_status, .rd_n, .wr_n, .interrupt_ack_strobe_n,
    .upper_byte_enable_n, .refresh_indicator_n, .transceiver_enable_n,
    .transceiver_direction, .lock_n, .chip_select_en);
  bus_partner i_far (.clk, .rst, .waits, .vec, .rd_n, .wr_n, .interrupt_ack_strobe_n,
    .bus_ready, .ad_in);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic idle(input int n);
    ale_cnt = 0;
    repeat (n) begin
      tick();
      if (ale === 1'b1) ale_cnt++;
    end
  endtask

  // Issues one request, then records the pins cycle by cycle until done, or until halted for a halt request.
  task automatic run(input bus_seq_pkg::kind_t k, input logic [19:0] a,
                     input logic [15:0] d, input logic wi, input logic wt);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    req_kind = k;
    {req_addr, req_wdata, wake_irq, wake_temp} = {a, d, wi, wt};
    req_valid = 1'b1;
    tick();
    {req_valid, wake_irq, wake_temp} = 3'b000;
    {ale_cnt, ack_cnt, wr_lo} = {32'd0, 32'd0, 32'd0};
    {refresh_indicator_lo, lock_lo, hold_ok, vec_got} = 11'h000;
    for (n = 0; n < 60; n++) begin
      if (ale === 1'b1) begin
        ale_cnt++;
        {st_ale, ad_ale, nib_ale, ube_ale} = {cycle_status, ad_out, upper_address_nibble,
                                             upper_byte_enable_n};
      end
      if (wr_n === 1'b0) wr_lo++;
      if (wr_n === 1'b0) wr_dat = ad_out;
      if (wr_n === 1'b1 && wr_lo > 0 && !hold_ok) hold_ok = ad_oe_n[7:0] === 8'h00;
      if (interrupt_ack_strobe_n === 1'b0 && i_far.cnt_r === 4'h0) ack_cnt++;
      if (refresh_indicator_n === 1'b0) refresh_indicator_lo = 1'b1;
      if (lock_n === 1'b0) lock_lo = 1'b1;
      if (vector_valid === 1'b1) vec_got = vector;
      if (done === 1'b1) break;
      if (k == bus_seq_pkg::KIND_HALT && halted === 1'b1) break;
      tick();
    end
    if (n >= 60) begin
      failures++;
      $display("[ERR] %0t no completion", $time);
      give_verdict();
    end
  endtask

  task automatic t_write;
    for (int i = 0; i < 4; i++) begin
      waits = i[1] ? 4'h2 : 4'h0;
      run(i[0] ? bus_seq_pkg::KIND_IOWR : bus_seq_pkg::KIND_MEMWR, 20'ha5c34 + 20'(i * 2),
          16'h1234 + 16'(i), 1'b0, 1'b0);
      check(st_ale, i[0] ? 3'h2 : 3'h6, "status");
      check(ad_ale, 16'h5c34 + 16'(i * 2), "address");
      check(nib_ale, i[0] ? 4'h0 : 4'ha, "nibble");
      check(wr_lo, 2 + waits, "strobe width");
      check(wr_dat, 16'h1234 + 16'(i), "data");
      check(hold_ok, 1'b1, "data hold");
    end
    $display("write test done");
  endtask

  task automatic t_refresh;
    for (int i = 0; i < 2; i++) begin
      bus16 = i[0];
      run(bus_seq_pkg::KIND_REFRESH, 20'h02460, 16'h0000, 1'b0, 1'b0);
      check(ad_ale[0], 1'b1, "refresh bit 0");
      check(refresh_indicator_lo, !bus16, "refresh flag");
      if (bus16) check(ube_ale, 1'b1, "refresh upper enable");
    end
    $display("refresh test done");
  endtask

  task automatic t_ack;
    {waits, vec} = {4'h1, 8'h3c};
    run(bus_seq_pkg::KIND_INTERRUPT_ACK_STROBE, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(ale_cnt, 2, "ack cycles");
    check(ack_cnt, 2, "ack strobes");
    check(lock_lo, 1'b1, "lock seen");
    check(vec_got, 8'h3c, "vector");
    idle(2);
    check(lock_n, 1'b1, "lock released");
    $display("acknowledge test done");
  endtask

  task automatic t_halt;
    waits = 4'h0;
    run(bus_seq_pkg::KIND_MEMWR, 20'h31000, 16'hbeef, 1'b0, 1'b0);
    run(bus_seq_pkg::KIND_HALT, 20'h00000, 16'h0000, 1'b0, 1'b0);
    check(st_ale, 3'h3, "halt status");
    check(nib_ale, 4'h3, "halt nibble");
    idle(8);
    check(halted, 1'b1, "halted");
    check(ale_cnt, 0, "stays halted");
    run(bus_seq_pkg::KIND_REFRESH, 20'h00100, 16'h0000, 1'b0, 1'b1);
    idle(8);
    check(halted, 1'b1, "back to halt");
    check(ale_cnt, 0, "no second halt cycle");
    run(bus_seq_pkg::KIND_MEMRD, 20'h02000, 16'h0000, 1'b1, 1'b0);
    check(st_ale, 3'h5, "read after wake");
    check(halted, 1'b0, "halt left");
    $display("halt test done");
  endtask

  initial begin
    {rst, bus16, req_valid, req_word, wake_irq, wake_temp} = 6'b110100;
    req_kind = bus_seq_pkg::KIND_MEMRD;
    {req_addr, req_wdata, waits, vec} = 48'h0;
    failures = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tick();
    t_write();
    t_refresh();
    t_ack();
    t_halt();
    give_verdict();
  end
endmodule
